/* File: pkg/fcs_pkg.sv */
package fcs_pkg;

  // Register map and command codes.
  localparam logic [7:0] FCS_ADDR_FLASH_COMMAND = 8'h62;
  localparam logic [7:0] FCS_RST_FLASH_COMMAND  = 8'h00;
  localparam logic [7:0] FCS_CMD_PROGRAM_BYTE   = 8'h0f;
  localparam logic [7:0] FCS_CMD_ERASE_PAGE0    = 8'h40;
  localparam logic [7:0] FCS_CMD_ERASE_PAGE1    = 8'h41;
  localparam logic [7:0] FCS_CMD_ERASE_PAGE2    = 8'h42;
  localparam logic [7:0] FCS_CMD_RAM_TO_FLASH   = 8'h45;
  localparam logic [7:0] FCS_CMD_FLASH_TO_RAM   = 8'h48;
  localparam logic [7:0] FCS_CMD_POWER_DOWN     = 8'hf6;

  // Flash geometry: three pages of 32 bytes.
  localparam logic [6:0] FCS_PAGE0_BASE = 7'h00;
  localparam logic [6:0] FCS_PAGE1_BASE = 7'h20;
  localparam logic [6:0] FCS_PAGE2_BASE = 7'h40;
  localparam logic [4:0] FCS_PAGE_LAST  = 5'h1f;
  localparam int         FCS_FLASH_SIZE = 96;
  localparam int         FCS_RAM_SIZE   = 32;
  localparam logic [7:0] FCS_ERASED     = 8'hff;

  // Wake-threshold field reset value.
  localparam logic [2:0] FCS_RST_WAKE_THRESHOLD = 3'h7;

  typedef enum logic [2:0] {
    FCS_IDLE,
    FCS_PROG,
    FCS_ERASE,
    FCS_R2F,
    FCS_F2R,
    FCS_WAIT_SLEEP,
    FCS_SLEEP
  } fcs_state_e;

endpackage

/* File: sim/fcs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Host side of the register path; it also owns the serial pin level.
module fcs_host_model
  import fcs_pkg::*;
(
  input  wire logic       CLK_I,   // Clock.
  output logic            WR_O,    // Write strobe.
  output logic            RD_O,    // Read strobe.
  output logic      [7:0] ADDR_O,  // Address.
  output logic      [7:0] WDATA_O, // Write data.
  input  wire logic [7:0] RDATA_I, // Read data.
  output logic            PIN_O    // Serial pin level.
);
  initial begin
    WR_O = 1'b0;
    RD_O = 1'b0;
    ADDR_O = 8'h00;
    WDATA_O = 8'h00;
    PIN_O = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    WR_O <= 1'b1;
    ADDR_O <= a;
    WDATA_O <= d;
    @(posedge CLK_I);
    WR_O <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_I);
    RD_O <= 1'b1;
    ADDR_O <= a;
    @(posedge CLK_I);
    RD_O <= 1'b0;
    @(negedge CLK_I);
    d = RDATA_I;
  endtask
  // Nothing else is issued until the register reads zero again, or 60 reads have gone by.
  task automatic run(input logic [7:0] c, output logic [7:0] d);
    wr(FCS_ADDR_FLASH_COMMAND, c);
    for (int i = 0; i < 60; i++) begin
      rd(FCS_ADDR_FLASH_COMMAND, d);
      if (d === 8'h00) break;
    end
  endtask
  task automatic toggle();
    @(posedge CLK_I);
    PIN_O <= ~PIN_O;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_flash_command_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_flash_command_sequencer
  import fcs_pkg::*;
;
  logic       clk, rst, wr, rd, ram_wr, pin, busy, sleep;
  logic [7:0] addr, wdata, rdata, pdata, sense, ramd, ramq, flq, got;
  logic [6:0] paddr, fla;
  logic [4:0] rama, ramwa;
  logic [2:0] wake;
  logic [7:0] fm [96];
  logic [7:0] rm [32];
  logic [31:0] seed;
  int         miscompares, tests_run, cycles, a;

  fcs_flash_command_sequencer dut (
    .CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .FLASH_PROGRAM_DATA_I(pdata), .FLASH_PROGRAM_ADDRESS_I(paddr),
    .WAKE_THRESHOLD_BITS_I(wake), .SENSE_MAGNITUDE_I(sense),
    .HOST_SERIAL_PIN_I(pin), .RAM_RD_ADDR_I(rama), .RAM_RD_DATA_O(ramq),
    .FLASH_RD_ADDR_I(fla), .FLASH_RD_DATA_O(flq), .RAM_WR_I(ram_wr),
    .RAM_WR_ADDR_I(ramwa), .RAM_WR_DATA_I(ramd), .BUSY_O(busy),
    .SLEEP_O(sleep));
  fcs_host_model host (.CLK_I(clk), .WR_O(wr), .RD_O(rd), .ADDR_O(addr),
    .WDATA_O(wdata), .RDATA_I(rdata), .PIN_O(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Both read ports are registered, so data is taken a cycle later.
  task automatic memrd(input logic fl, input int ad);
    @(posedge clk);
    fla <= 7'(ad);
    rama <= 5'(ad);
    @(posedge clk);
    @(negedge clk);
    got = fl ? flq : ramq;
  endtask
  task automatic check_flash();
    for (int i = 0; i < 96; i++) begin
      memrd(1'b1, i);
      chk(got, fm[i]);
    end
  endtask
  task automatic fill_ram();
    for (int i = 0; i < 32; i++) begin
      rm[i] = 8'(rnd());
      @(posedge clk);
      ram_wr <= 1'b1;
      ramwa <= 5'(i);
      ramd <= rm[i];
    end
    @(posedge clk);
    ram_wr <= 1'b0;
  endtask
  task automatic wait_sleep(input logic v);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (sleep === v) break;
    end
    chk({7'h00, sleep}, {7'h00, v});
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    {rst, seed, wake, sense} = {1'b1, 32'd52758, 3'h7, 8'hff};
    {ram_wr, pdata, paddr, fla, rama, ramwa, ramd} = '0;
    {cycles, miscompares, tests_run} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host.rd(FCS_ADDR_FLASH_COMMAND, got);
    chk(got, FCS_RST_FLASH_COMMAND);
    host.rd(8'h63, got);
    chk(got, 8'h00);
    for (int p = 0; p < 3; p++) begin
      host.run(8'(FCS_CMD_ERASE_PAGE0 + p), got);
      chk(got, 8'h00);
    end
    for (int i = 0; i < 96; i++) fm[i] = FCS_ERASED;
    check_flash();
    // The two ends of the array and a repeated hit on one byte come first.
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 0 : (i < 3) ? 95 : int'(rnd() % 96);
      @(posedge clk);
      paddr <= 7'(a);
      pdata <= 8'(rnd());
      host.run(FCS_CMD_PROGRAM_BYTE, got);
      chk(got, 8'h00);
      fm[a] = fm[a] & pdata;
      memrd(1'b1, a);
      chk(got, fm[a]);
    end
    host.run(FCS_CMD_ERASE_PAGE1, got);
    for (int i = 32; i < 64; i++) fm[i] = FCS_ERASED;
    check_flash();
    host.run(8'h13, got);
    chk(got, 8'h00);
    check_flash();
    fill_ram();
    host.run(FCS_CMD_ERASE_PAGE0, got);
    host.run(FCS_CMD_RAM_TO_FLASH, got);
    for (int i = 0; i < 32; i++) fm[i] = rm[i];
    check_flash();
    fill_ram();
    host.run(FCS_CMD_FLASH_TO_RAM, got);
    for (int i = 0; i < 32; i++) begin
      memrd(1'b0, i);
      chk(got, fm[i]);
    end
    // Full-scale sense at the reset threshold must hold sleep off.
    @(posedge clk);
    wake <= FCS_RST_WAKE_THRESHOLD;
    sense <= 8'hff;
    host.wr(FCS_ADDR_FLASH_COMMAND, FCS_CMD_POWER_DOWN);
    repeat (10) @(negedge clk);
    chk({7'h00, sleep}, 8'h00);
    chk({7'h00, busy}, 8'h01);
    // A magnitude equal to the threshold is not below it.
    @(posedge clk);
    wake <= 3'h2;
    sense <= 8'h40;
    repeat (30) @(negedge clk);
    chk({7'h00, sleep}, 8'h00);
    @(posedge clk);
    sense <= 8'h3f;
    wait_sleep(1'b1);
    repeat (30) @(negedge clk);
    chk({7'h00, sleep}, 8'h01);
    host.toggle();
    wait_sleep(1'b0);
    host.rd(FCS_ADDR_FLASH_COMMAND, got);
    chk(got, 8'h00);
    @(posedge clk);
    wake <= 3'h0;
    sense <= 8'hff;
    host.wr(FCS_ADDR_FLASH_COMMAND, FCS_CMD_POWER_DOWN);
    wait_sleep(1'b1);
    host.toggle();
    wait_sleep(1'b0);
    chk({7'h00, busy}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: verilog/fcs_flash_command_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RL1 - Host writes command code to register 0x62.
// RL2 - Register returns to zero when done.
// RL3 - Code 0x0F ANDs data into addressed byte.
// RL4 - Code 0x40 erases locations 0x00-0x1F.
// RL5 - Code 0x41 erases locations 0x20-0x3F.
// RL6 - Code 0x42 erases locations 0x40-0x5F.
// RL7 - Code 0x45 programs RAM into page 0.
// RL8 - Code 0x48 copies page 0 into RAM.
// RL9 - Code 0xF6 sleeps once threshold condition met.
// RL10 - Sleep ends on any serial pin edge.
// RL11 - Sleep only while sense magnitude below threshold; checked only on entry, not while asleep.
// RL12 - Threshold resets to ones; zero sleeps immediately.
// RL13 - Host waits for zero before next command.
// RL14 - Unknown code does nothing, register cleared.
module fcs_flash_command_sequencer
  import fcs_pkg::*;
(
  input  wire logic       CLK_I,                   // Clock, 100 MHz.
  input  wire logic       SYS_RST_I,               // Sync reset, high.
  input  wire logic       REG_WR_I,                // Register write strobe.
  input  wire logic       REG_RD_I,                // Register read strobe.
  input  wire logic [7:0] REG_ADDR_I,              // Register address.
  input  wire logic [7:0] REG_WDATA_I,             // Write data.
  output logic      [7:0] REG_RDATA_O,             // Read data.
  input  wire logic [7:0] FLASH_PROGRAM_DATA_I,    // Program-data register.
  input  wire logic [6:0] FLASH_PROGRAM_ADDRESS_I, // Program-address reg.
  input  wire logic [2:0] WAKE_THRESHOLD_BITS_I,   // Mode bits 3..1.
  input  wire logic [7:0] SENSE_MAGNITUDE_I,       // |pos - neg| sense code.
  input  wire logic       HOST_SERIAL_PIN_I,       // Serial pin level.
  input  wire logic [4:0] RAM_RD_ADDR_I,           // RAM read port address.
  output logic      [7:0] RAM_RD_DATA_O,           // RAM read port data.
  input  wire logic [6:0] FLASH_RD_ADDR_I,         // Flash read port addr.
  output logic      [7:0] FLASH_RD_DATA_O,         // Flash read port data.
  input  wire logic       RAM_WR_I,                // Host RAM write strobe.
  input  wire logic [4:0] RAM_WR_ADDR_I,           // Host RAM write addr.
  input  wire logic [7:0] RAM_WR_DATA_I,           // Host RAM write data.
  output logic            BUSY_O,                  // Command in progress.
  output logic            SLEEP_O                  // Device asleep.
);

  typedef struct packed {
    fcs_state_e  state;
    logic [7:0]  flash_command_reg;
    logic [4:0]  idx;
    logic [6:0]  base;
    logic        pin_last;
    logic [7:0]  rdata;
    logic [7:0]  ram_q;
    logic [7:0]  flash_q;
    logic        sleep;
  } fcs_main_s;

  fcs_main_s  st;
  fcs_main_s  next_st;
  logic [7:0] flash_mem [FCS_FLASH_SIZE];
  logic [7:0] ram_mem   [FCS_RAM_SIZE];
  logic       pin_sync;
  logic       cmd_write;
  logic       below_threshold;
  logic       pin_edge;
  logic [6:0] cur_addr;

  fcs_sync u_pin_sync (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .d_i       (HOST_SERIAL_PIN_I),
    .q_o       (pin_sync)
  );

  assign cmd_write = REG_WR_I && (REG_ADDR_I == FCS_ADDR_FLASH_COMMAND);
  // The sense code is compared against the 3-bit threshold scaled to
  // the code's top bits; zero always passes, so zero sleeps at once.
  assign below_threshold = (WAKE_THRESHOLD_BITS_I == 3'h0) ||
                           (SENSE_MAGNITUDE_I < {WAKE_THRESHOLD_BITS_I,
                                                 5'h00}); // [RL11] [RL12]
  assign pin_edge = pin_sync ^ st.pin_last; // [RL10]
  assign cur_addr = st.base + {2'b00, st.idx};

  always_comb begin
    next_st = st;
    next_st.pin_last = pin_sync;
    next_st.flash_q = flash_mem[FLASH_RD_ADDR_I];
    next_st.ram_q = ram_mem[RAM_RD_ADDR_I];
    next_st.rdata = 8'h00;
    if (REG_RD_I && (REG_ADDR_I == FCS_ADDR_FLASH_COMMAND)) begin
      next_st.rdata = st.flash_command_reg;
    end
    case (st.state)
      FCS_IDLE: begin
        next_st.idx = 5'h00;
        // Writes while busy are dropped; the host must poll first.
        if (cmd_write) begin // [RL1] [RL13]
          next_st.flash_command_reg = REG_WDATA_I;
          if (REG_WDATA_I == FCS_CMD_PROGRAM_BYTE) begin
            next_st.state = FCS_PROG;
          end else if (REG_WDATA_I == FCS_CMD_ERASE_PAGE0) begin
            next_st.state = FCS_ERASE;
            next_st.base = FCS_PAGE0_BASE; // [RL4]
          end else if (REG_WDATA_I == FCS_CMD_ERASE_PAGE1) begin
            next_st.state = FCS_ERASE;
            next_st.base = FCS_PAGE1_BASE; // [RL5]
          end else if (REG_WDATA_I == FCS_CMD_ERASE_PAGE2) begin
            next_st.state = FCS_ERASE;
            next_st.base = FCS_PAGE2_BASE; // [RL6]
          end else if (REG_WDATA_I == FCS_CMD_RAM_TO_FLASH) begin
            next_st.state = FCS_R2F;
            next_st.base = FCS_PAGE0_BASE;
          end else if (REG_WDATA_I == FCS_CMD_FLASH_TO_RAM) begin
            next_st.state = FCS_F2R;
            next_st.base = FCS_PAGE0_BASE;
          end else if (REG_WDATA_I == FCS_CMD_POWER_DOWN) begin
            next_st.state = FCS_WAIT_SLEEP;
          end else begin
            next_st.flash_command_reg = FCS_RST_FLASH_COMMAND; // [RL14]
          end
        end
      end
      FCS_PROG: begin
        next_st.state = FCS_IDLE;
        next_st.flash_command_reg = FCS_RST_FLASH_COMMAND; // [RL2]
      end
      FCS_ERASE, FCS_R2F, FCS_F2R: begin
        next_st.idx = st.idx + 5'h01;
        if (st.idx == FCS_PAGE_LAST) begin
          next_st.state = FCS_IDLE;
          next_st.flash_command_reg = FCS_RST_FLASH_COMMAND; // [RL2]
        end
      end
      FCS_WAIT_SLEEP: begin
        if (below_threshold) begin // [RL9]
          next_st.state = FCS_SLEEP;
          next_st.sleep = 1'b1;
        end
      end
      FCS_SLEEP: begin
        if (pin_edge) begin // [RL10]
          next_st.state = FCS_IDLE;
          next_st.sleep = 1'b0;
          next_st.flash_command_reg = FCS_RST_FLASH_COMMAND; // [RL2]
        end
      end
      default: begin
        next_st.state = FCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st.state <= FCS_IDLE;
      st.flash_command_reg <= FCS_RST_FLASH_COMMAND;
      st.idx <= 5'h00;
      st.base <= FCS_PAGE0_BASE;
      st.pin_last <= 1'b0;
      st.rdata <= 8'h00;
      st.ram_q <= 8'h00;
      st.flash_q <= 8'h00;
      st.sleep <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Arrays carry no reset: flash contents are nonvolatile by intent.
  always_ff @(posedge CLK_I) begin
    if (st.state == FCS_PROG) begin
      flash_mem[FLASH_PROGRAM_ADDRESS_I] <=
        flash_mem[FLASH_PROGRAM_ADDRESS_I] & FLASH_PROGRAM_DATA_I; // [RL3]
    end else if (st.state == FCS_ERASE) begin
      flash_mem[cur_addr] <= FCS_ERASED; // [RL4] [RL5] [RL6]
    end else if (st.state == FCS_R2F) begin
      flash_mem[cur_addr] <= ram_mem[st.idx]; // [RL7]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (st.state == FCS_F2R) begin
      ram_mem[st.idx] <= flash_mem[cur_addr]; // [RL8]
    end else if (RAM_WR_I && !BUSY_O) begin
      ram_mem[RAM_WR_ADDR_I] <= RAM_WR_DATA_I;
    end
  end

  assign REG_RDATA_O     = st.rdata;
  assign RAM_RD_DATA_O   = st.ram_q;
  assign FLASH_RD_DATA_O = st.flash_q;
  assign BUSY_O          = (st.state != FCS_IDLE);
  assign SLEEP_O         = st.sleep;

  property p_clear_after_erase;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_IDLE && cmd_write &&
       REG_WDATA_I == FCS_CMD_ERASE_PAGE1) |-> ##33
      (st.flash_command_reg == 8'h00 && st.state == FCS_IDLE);
  endproperty
  a_clear_after_erase: assert property (p_clear_after_erase) // [RL2]
    else $error("erase did not finish in 32 cycles");

  property p_prog_and;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_PROG) |=>
      flash_mem[$past(FLASH_PROGRAM_ADDRESS_I)] ==
      ($past(flash_mem[FLASH_PROGRAM_ADDRESS_I]) &
       $past(FLASH_PROGRAM_DATA_I));
  endproperty
  a_prog_and: assert property (p_prog_and) // [RL3]
    else $error("program byte is not an AND");

  property p_unknown_clears;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_IDLE && cmd_write && REG_WDATA_I == 8'h13) |=>
      (st.flash_command_reg == 8'h00 && st.state == FCS_IDLE);
  endproperty
  a_unknown_clears: assert property (p_unknown_clears) // [RL14]
    else $error("unknown code was not ignored");

  property p_sleep_gate;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_WAIT_SLEEP) |=>
      (st.sleep == $past(below_threshold));
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) // [RL9]
    else $error("sleep entry not gated by threshold");

  property p_zero_threshold;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_WAIT_SLEEP && WAKE_THRESHOLD_BITS_I == 3'h0) |=>
      SLEEP_O;
  endproperty
  a_zero_threshold: assert property (p_zero_threshold) // [RL12]
    else $error("zero threshold did not sleep at once");

  property p_wake;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (SLEEP_O && pin_edge) |=> (!SLEEP_O && st.flash_command_reg == 8'h00);
  endproperty
  a_wake: assert property (p_wake) // [RL10]
    else $error("no wake on pin edge");

  property p_stay_asleep;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (SLEEP_O && !pin_edge) |=> SLEEP_O;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) // [RL10]
    else $error("left sleep without pin edge");

  property p_sense_block;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_WAIT_SLEEP && WAKE_THRESHOLD_BITS_I == 3'h7 &&
       SENSE_MAGNITUDE_I == 8'hff) |=> !SLEEP_O;
  endproperty
  a_sense_block: assert property (p_sense_block) // [RL11]
    else $error("slept with sense above threshold");

  property p_cmd_held;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (st.state == FCS_IDLE && cmd_write &&
       REG_WDATA_I == FCS_CMD_FLASH_TO_RAM) |=>
      (st.flash_command_reg == 8'h48) [*8];
  endproperty
  a_cmd_held: assert property (p_cmd_held) // [RL1] [RL8]
    else $error("command code not held while busy");

endmodule
`default_nettype wire

/* File: verilog/fcs_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for one pin level.
module fcs_sync
  import fcs_pkg::*;
(
  input  wire logic CLK_I,     // Clock.
  input  wire logic SYS_RST_I, // Synchronous reset.
  input  wire logic d_i,       // Asynchronous level.
  output logic      q_o        // Synchronised level.
);

  typedef struct packed {
    logic meta;
    logic sync;
  } fcs_sync_s;

  fcs_sync_s st;
  fcs_sync_s next_st;

  always_comb begin
    next_st.meta = d_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.sync;

endmodule
`default_nettype wire
